// ===== rtl/multimode_up_counter.sv
// Multimode 16-bit up timer/counter with four modes and sub-modes
`timescale 1ns/1ps
module multimode_up_counter (
   input wire logic core_clk, // 20 MHz system clock
   input wire logic rst_b, // Async reset, active low
   input wire logic measurement_interface_clock, // Timer source pin
   input wire logic low_power_clock, // Alternate timer source pin
   input wire logic low_power_clock_second, // 100 kHz clock to measure
   input wire logic event_in, // Counter function input pin
   input wire logic trigger, // Start pulse, same clock domain
   input wire logic run, // Counting enable
   input wire logic counter_function, // 1: count event falling edges
   input wire logic source_select, // 0: measurement clock, 1: low power
   input wire logic [1:0] prescale, // 0 none, 1 /2, 2 /4, 3 /8
   input wire logic [1:0] mode, // Operating mode 0..3
   input wire logic sub_mode_b, // Sub-mode b in modes 1 and 3
   input wire logic load_low, // Write strobe for low byte
   input wire logic load_high, // Write strobe for high byte
   input wire logic [7:0] load_data, // Data for the load strobes
   output logic [7:0] count_low_byte, // Low count byte
   output logic [7:0] count_high_byte, // High count byte
   output logic [7:0] period_capture, // Mode 3b time between edges
   output logic overflow_low, // Low byte overflow pulse
   output logic overflow_high, // High byte overflow pulse
   output logic measurement_start, // Single shot start to measure unit
   output logic shot_busy // Single shot armed or counting
);
   pin_sample_if #(.N(up_timer_pkg::NUM_PIN_INPUTS)) smp ();

   pin_sampler #(.N(up_timer_pkg::NUM_PIN_INPUTS)) u_sampler (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .pin_raw({event_in, low_power_clock_second, low_power_clock,
                measurement_interface_clock}),
      .smp(smp.drv)
   );

   // Sources are sampled at core_clk, so each level must last two cycles: at most a quarter of it
   logic src_tick;
   always_comb begin
      if (counter_function) begin
         src_tick = smp.fall[up_timer_pkg::PIN_EVENT];
      end else if (source_select) begin
         src_tick = smp.rise[up_timer_pkg::PIN_LOW_POWER_CLOCK];
      end else begin
         src_tick = smp.rise[up_timer_pkg::PIN_MEAS_CLK];
      end
   end

   logic [2:0] pre_cnt;
   logic [2:0] next_pre_cnt;
   logic pre_en;
   always_comb begin
      next_pre_cnt = pre_cnt;
      if (!run) begin
         next_pre_cnt = up_timer_pkg::PRESCALE_RESET;
      end else if (src_tick) begin
         next_pre_cnt = pre_cnt + 3'h1;
      end
      case (up_timer_pkg::prescale_e'(prescale))
         up_timer_pkg::DIV_2: pre_en = src_tick & pre_cnt[0];
         up_timer_pkg::DIV_4: pre_en = src_tick & (&pre_cnt[1:0]);
         up_timer_pkg::DIV_8: pre_en = src_tick & (&pre_cnt);
         default: pre_en = src_tick;
      endcase
   end

   // Single shot sequencing for mode 1b
   up_timer_pkg::shot_state_e shot;
   up_timer_pkg::shot_state_e next_shot;
   logic next_meas_start;
   logic shot_mode;
   logic wrap16;
   assign shot_mode = run && sub_mode_b &&
      (mode == up_timer_pkg::MODE_16BIT);
   always_comb begin
      next_shot = shot;
      next_meas_start = 1'b0;
      case (shot)
         up_timer_pkg::SHOT_IDLE: begin
            if (shot_mode) begin
               next_shot = up_timer_pkg::SHOT_WAIT;
            end
         end
         up_timer_pkg::SHOT_WAIT: begin
            if (!shot_mode) begin
               next_shot = up_timer_pkg::SHOT_IDLE;
            end else if (trigger) begin
               next_shot = up_timer_pkg::SHOT_COUNT;
               next_meas_start = 1'b1;
            end
         end
         up_timer_pkg::SHOT_COUNT: begin
            if (!shot_mode) begin
               next_shot = up_timer_pkg::SHOT_IDLE;
            end else if (wrap16) begin
               next_shot = up_timer_pkg::SHOT_DONE;
            end
         end
         up_timer_pkg::SHOT_DONE: begin
            // Stays stopped until run or mode drops, so one shot only
            if (!shot_mode) begin
               next_shot = up_timer_pkg::SHOT_IDLE;
            end
         end
         default: next_shot = up_timer_pkg::SHOT_IDLE;
      endcase
   end

   logic cnt_en;
   assign cnt_en = run && pre_en &&
      (!shot_mode || shot == up_timer_pkg::SHOT_COUNT);

   logic [7:0] next_low;
   logic [7:0] next_high;
   logic [7:0] next_capture;
   logic next_ovl;
   logic next_ovh;
   logic [8:0] sum_low;
   logic [8:0] sum_high;
   logic [5:0] sum_pre;
   logic [16:0] sum_all;
   logic lp2_edge;
   assign lp2_edge = run && smp.rise[up_timer_pkg::PIN_LOW_POWER_CLOCK_SECOND];
   assign wrap16 = cnt_en && sum_all[16];

   always_comb begin
      next_low = count_low_byte;
      next_high = count_high_byte;
      next_capture = period_capture;
      next_ovl = 1'b0;
      next_ovh = 1'b0;
      sum_low = {1'b0, count_low_byte} + 9'h001;
      sum_high = {1'b0, count_high_byte} + 9'h001;
      sum_pre = {1'b0, count_low_byte[4:0]} + 6'h01;
      sum_all = {1'b0, count_high_byte, count_low_byte} + 17'h0_0001;
      case (up_timer_pkg::timer_mode_e'(mode))
         up_timer_pkg::MODE_13BIT: begin
            if (cnt_en) begin
               next_low[4:0] = sum_pre[4:0];
               if (sum_pre[5]) begin
                  next_high = sum_high[7:0];
                  next_ovh = sum_high[8];
               end
            end
         end
         up_timer_pkg::MODE_16BIT: begin
            if (cnt_en) begin
               next_low = sum_all[7:0];
               next_high = sum_all[15:8];
               next_ovl = sum_low[8];
               next_ovh = sum_all[16];
            end
         end
         up_timer_pkg::MODE_RELOAD8: begin
            if (cnt_en) begin
               if (sum_low[8]) begin
                  next_low = count_high_byte;
                  next_ovl = 1'b1;
               end else begin
                  next_low = sum_low[7:0];
               end
            end
         end
         up_timer_pkg::MODE_SPLIT8: begin
            if (!sub_mode_b) begin
               if (cnt_en) begin
                  next_low = sum_low[7:0];
                  next_high = sum_high[7:0];
                  next_ovl = sum_low[8];
                  next_ovh = sum_high[8];
               end
            end else begin
               // Edge wins over a time tick in the same cycle
               if (lp2_edge) begin
                  next_low = sum_low[7:0];
                  next_ovl = sum_low[8];
                  next_capture = count_high_byte;
                  next_high = up_timer_pkg::COUNT_HIGH_RESET;
               end else if (cnt_en) begin
                  next_high = sum_high[7:0];
                  next_ovh = sum_high[8];
               end
            end
         end
         default: begin
            next_low = count_low_byte;
         end
      endcase
      // Software load wins over counting in the same cycle
      if (load_low) begin
         next_low = load_data;
      end
      if (load_high) begin
         next_high = load_data;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pre_cnt <= up_timer_pkg::PRESCALE_RESET;
         shot <= up_timer_pkg::SHOT_IDLE;
         measurement_start <= 1'b0;
         count_low_byte <= up_timer_pkg::COUNT_LOW_RESET;
         count_high_byte <= up_timer_pkg::COUNT_HIGH_RESET;
         period_capture <= up_timer_pkg::CAPTURE_RESET;
         overflow_low <= 1'b0;
         overflow_high <= 1'b0;
      end else begin
         pre_cnt <= next_pre_cnt;
         shot <= next_shot;
         measurement_start <= next_meas_start;
         count_low_byte <= next_low;
         count_high_byte <= next_high;
         period_capture <= next_capture;
         overflow_low <= next_ovl;
         overflow_high <= next_ovh;
      end
   end

   assign shot_busy = (shot == up_timer_pkg::SHOT_WAIT) ||
      (shot == up_timer_pkg::SHOT_COUNT);
endmodule

// ===== shared/up_timer_pkg.sv
// Constants and types shared by the multimode up counter
package up_timer_pkg;
   localparam int SYNC_STAGES = 3;
   localparam int NUM_PIN_INPUTS = 4;
   // Index of each sampled pin in the sampler vector
   localparam int PIN_MEAS_CLK = 0;
   localparam int PIN_LOW_POWER_CLOCK = 1;
   localparam int PIN_LOW_POWER_CLOCK_SECOND = 2;
   localparam int PIN_EVENT = 3;
   localparam int LOW_POWER_CLOCK_SECOND_FREQ_HZ = 100000;
   localparam int PRESCALE_BITS = 3;
   localparam int MODE0_PRESCALE_BITS = 5;
   localparam logic [7:0] COUNT_LOW_RESET = 8'h00;
   localparam logic [7:0] COUNT_HIGH_RESET = 8'h00;
   localparam logic [7:0] CAPTURE_RESET = 8'h00;
   localparam logic [2:0] PRESCALE_RESET = 3'h0;

   typedef enum logic [1:0] {
      MODE_13BIT = 2'b00,
      MODE_16BIT = 2'b01,
      MODE_RELOAD8 = 2'b10,
      MODE_SPLIT8 = 2'b11
   } timer_mode_e;

   typedef enum logic [1:0] {
      DIV_NONE = 2'b00,
      DIV_2 = 2'b01,
      DIV_4 = 2'b10,
      DIV_8 = 2'b11
   } prescale_e;

   typedef enum logic [1:0] {
      SHOT_IDLE = 2'b00,
      SHOT_WAIT = 2'b01,
      SHOT_COUNT = 2'b10,
      SHOT_DONE = 2'b11
   } shot_state_e;
endpackage

// ===== shared/pin_sample_if.sv
// Filtered pin levels and edge pulses from the sampler
`timescale 1ns/1ps
interface pin_sample_if #(
   parameter int N = 4
);
   logic [N-1:0] level;
   logic [N-1:0] rise;
   logic [N-1:0] fall;
   modport drv (output level, output rise, output fall);
   modport mon (input level, input rise, input fall);
endinterface

// ===== rtl/pin_sampler.sv
// Three-stage synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module pin_sampler #(
   parameter int N = 4
) (
   input wire logic core_clk, // System clock
   input wire logic rst_b, // Async reset, active low
   input wire logic [N-1:0] pin_raw, // Asynchronous pin levels
   pin_sample_if.drv smp // Filtered levels and edges
);
   // Refused at elaboration, not at run time
   if (N < 1) begin : g_bad_width
      $error("pin_sampler needs at least one input");
   end

   logic [N-1:0] stage1;
   logic [N-1:0] stage2;
   logic [N-1:0] stage3;
   logic [N-1:0] level;
   logic [N-1:0] next_level;
   logic [N-1:0] rise;
   logic [N-1:0] next_rise;
   logic [N-1:0] fall;
   logic [N-1:0] next_fall;

   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_pin
         // A change counts only once stages two and three agree
         always_comb begin
            next_level[i] = level[i];
            if (stage2[i] == stage3[i]) begin
               next_level[i] = stage3[i];
            end
            next_rise[i] = next_level[i] & ~level[i];
            next_fall[i] = ~next_level[i] & level[i];
         end
      end
   endgenerate

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
         level <= '0;
         rise <= '0;
         fall <= '0;
      end else begin
         stage1 <= pin_raw;
         stage2 <= stage1;
         stage3 <= stage2;
         level <= next_level;
         rise <= next_rise;
         fall <= next_fall;
      end
   end

   assign smp.level = level;
   assign smp.rise = rise;
   assign smp.fall = fall;
endmodule

// ===== test/pin_source_model.sv
// Far-side pin driver: timer sources, low power clocks, event input
`timescale 1ns/1ps
module pin_source_model (
   input wire logic core_clk, // System clock
   output logic [3:0] pins // Pin levels
);
   // Event input idles high so its first move is a fall
   initial pins = 4'b1000;
   // Each level held hold cycles; under two the sampler may miss it
   task automatic pulse(input int idx, input int n, input int hold);
      repeat (n) begin
         repeat (2) begin
            @(posedge core_clk);
            pins[idx] <= ~pins[idx];
            repeat (hold - 1) @(posedge core_clk);
         end
      end
      repeat (8) @(posedge core_clk);
   endtask
endmodule

// ===== test/multimode_up_counter_checker.sv
// Port assertions for the multimode up counter
`timescale 1ns/1ps
module multimode_up_counter_checker (
   input wire logic core_clk, // Clock
   input wire logic rst_b, // Reset
   input wire logic run, // Enable
   input wire logic trigger, // Start
   input wire logic [1:0] mode, // Mode
   input wire logic sub_mode_b, // Sub-mode
   input wire logic load_low, // Strobe
   input wire logic load_high, // Strobe
   input wire logic [7:0] load_data, // Data
   input wire logic [7:0] count_low_byte, // Low
   input wire logic [7:0] count_high_byte, // High
   input wire logic [7:0] period_capture, // Capture
   input wire logic overflow_low, // Pulse
   input wire logic overflow_high, // Pulse
   input wire logic measurement_start, // Pulse
   input wire logic shot_busy // Busy
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   load_low_a: assert property (load_low |=>
      count_low_byte == $past(load_data)) else $error("low load lost");
   load_high_a: assert property (load_high |=>
      count_high_byte == $past(load_data)) else $error("high load lost");
   idle_hold_a: assert property (!$past(run) && !$past(load_low) &&
      !$past(load_high) && $past(mode) != 2'd3 |-> $stable(count_low_byte)
      && $stable(count_high_byte)) else $error("count moved while idle");
   up_step_a: assert property ($past(mode) == 2'd1 && !$past(load_low)
      && count_low_byte != $past(count_low_byte) |-> count_low_byte ==
      $past(count_low_byte) + 8'h01) else $error("not an up step");
   wrap_low_a: assert property (overflow_low && $past(mode) != 2'd2 |->
      count_low_byte == 8'h00) else $error("low overflow without wrap");
   wrap_full_a: assert property (overflow_high && $past(mode) == 2'd1 |->
      overflow_low && {count_high_byte, count_low_byte} == 16'h0000)
      else $error("16-bit wrap wrong");
   mode0_low_a: assert property ($past(mode) == 2'd0 |-> !overflow_low)
      else $error("low overflow in mode 0");
   mode0_wrap_a: assert property (overflow_high && $past(mode) == 2'd0
      |-> count_high_byte == 8'h00 && count_low_byte[4:0] == 5'h00)
      else $error("mode 0 carry wrong");
   reload_value_a: assert property (overflow_low && $past(mode) == 2'd2 &&
      !$past(load_high) |-> count_low_byte == count_high_byte)
      else $error("reload value wrong");
   shot_mode_a: assert property (shot_busy |-> $past(run) &&
      $past(mode) == 2'd1 && $past(sub_mode_b)) else $error("busy outside 1b");
   shot_start_a: assert property (measurement_start |-> shot_busy &&
      ($past(trigger) || $past(trigger, 2)) ##1 !measurement_start)
      else $error("start pulse wrong");
   cover property (overflow_high);
   cover property (measurement_start);
   cover property ($changed(period_capture));
   cover property (overflow_high && sub_mode_b && mode == 2'd1);
endmodule
bind multimode_up_counter multimode_up_counter_checker u_chk (.core_clk,
   .rst_b, .run, .trigger, .mode, .sub_mode_b, .load_low, .load_high,
   .load_data, .count_low_byte, .count_high_byte, .period_capture,
   .overflow_low, .overflow_high, .measurement_start, .shot_busy);

// ===== test/multimode_up_counter_tb.sv
// Self-checking bench for the multimode up counter
`timescale 1ns/1ps
module multimode_up_counter_tb;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] pins;
   logic trigger = 1'b0, run = 1'b0, counter_function = 1'b0;
   logic source_select = 1'b0, sub_mode_b = 1'b0;
   logic [1:0] prescale = 2'h0, mode = 2'h0;
   logic load_low = 1'b0, load_high = 1'b0;
   logic [7:0] load_data = 8'h00, lo, hi, cap;
   logic ovl, ovh, mst, busy;
   int miscompares = 0, checked = 0, cycles = 0, n_ol = 0, n_oh = 0, n_ms = 0;
   always #25 core_clk = ~core_clk;
   pin_source_model src (.core_clk(core_clk), .pins(pins));
   multimode_up_counter DUT (.core_clk(core_clk), .rst_b(rst_b),
      .measurement_interface_clock(pins[0]), .low_power_clock(pins[1]),
      .low_power_clock_second(pins[2]), .event_in(pins[3]),
      .trigger(trigger), .run(run), .counter_function(counter_function),
      .source_select(source_select), .prescale(prescale), .mode(mode),
      .sub_mode_b(sub_mode_b), .load_low(load_low), .load_high(load_high),
      .load_data(load_data), .count_low_byte(lo), .count_high_byte(hi),
      .period_capture(cap), .overflow_low(ovl), .overflow_high(ovh),
      .measurement_start(mst), .shot_busy(busy));
   always @(posedge core_clk) begin
      n_ol += (ovl === 1'b1);
      n_oh += (ovh === 1'b1);
      n_ms += (mst === 1'b1);
      cycles++;
      // Whole run needs a few hundred cycles
      if (cycles == 20000) begin
         miscompares++;
         print_verdict;
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Run drops first so the prescaler and single shot restart
   task automatic setup(input logic [1:0] m, input logic sb, input logic cf,
      input logic [1:0] ps, input logic [7:0] l, input logic [7:0] h);
      @(posedge core_clk);
      run <= 1'b0;
      mode <= m;
      sub_mode_b <= sb;
      counter_function <= cf;
      prescale <= ps;
      source_select <= ps[0];
      load_low <= 1'b1;
      load_data <= l;
      @(posedge core_clk);
      load_low <= 1'b0;
      load_high <= 1'b1;
      load_data <= h;
      @(posedge core_clk);
      load_high <= 1'b0;
      run <= 1'b1;
   endtask
   task automatic t_prescale;
      for (int p = 0; p < 4; p++) begin
         setup(2'd1, 1'b0, 1'b0, p[1:0], 8'h00, 8'h00);
         src.pulse(p % 2, (1 << p) - 1, 2 + p);
         check({hi, lo}, 16'h0000);
         src.pulse(p % 2, 1, 3);
         check({hi, lo}, 16'h0001);
      end
      $display("prescale done");
   endtask
   task automatic t_wraps;
      int bl, bh;
      bl = n_ol;
      bh = n_oh;
      setup(2'd1, 1'b0, 1'b0, 2'd0, 8'hFF, 8'hFF);
      src.pulse(0, 1, 3);
      check({hi, lo}, 16'h0000);
      check(16'(n_ol - bl), 16'h0001);
      check(16'(n_oh - bh), 16'h0001);
      setup(2'd0, 1'b0, 1'b0, 2'd0, 8'hBE, 8'hFF);
      src.pulse(0, 2, 3);
      check({hi, lo}, 16'h00A0);
      check(16'(n_ol - bl), 16'h0001);
      check(16'(n_oh - bh), 16'h0002);
      setup(2'd2, 1'b0, 1'b0, 2'd0, 8'hFF, 8'hF0);
      src.pulse(0, 2, 2);
      check({hi, lo}, 16'hF0F1);
      check(16'(n_ol - bl), 16'h0002);
      setup(2'd3, 1'b0, 1'b0, 2'd0, 8'hFF, 8'h10);
      src.pulse(0, 1, 4);
      check({hi, lo}, 16'h1100);
      check(16'(n_oh - bh), 16'h0002);
      check(16'(n_ol - bl), 16'h0003);
      $display("wraps done");
   endtask
   task automatic t_event_and_lp2;
      setup(2'd1, 1'b0, 1'b1, 2'd0, 8'h00, 8'h00);
      src.pulse(3, 3, 3);
      src.pulse(0, 2, 3);
      check({hi, lo}, 16'h0003);
      setup(2'd3, 1'b1, 1'b0, 2'd0, 8'h00, 8'h00);
      src.pulse(2, 1, 3);
      src.pulse(0, 4, 3);
      src.pulse(2, 1, 3);
      check({hi, lo}, 16'h0002);
      check({8'h00, cap}, 16'h0004);
      $display("event and lp2 done");
   endtask
   // One-cycle start pulse; first edge lets an armed shot reach its wait state
   task automatic fire_trigger;
      @(posedge core_clk);
      trigger <= 1'b1;
      @(posedge core_clk);
      trigger <= 1'b0;
   endtask
   task automatic t_shot;
      int bm;
      bm = n_ms;
      setup(2'd1, 1'b1, 1'b0, 2'd0, 8'h00, 8'h00);
      src.pulse(0, 2, 3);
      check({hi, lo}, 16'h0000);
      check({15'h0000, busy}, 16'h0001);
      fire_trigger;
      src.pulse(0, 2, 3);
      check({hi, lo}, 16'h0002);
      check(16'(n_ms - bm), 16'h0001);
      // Wrap ends the shot, so the second tick must be ignored
      setup(2'd1, 1'b1, 1'b0, 2'd0, 8'hFF, 8'hFF);
      fire_trigger;
      src.pulse(0, 2, 3);
      check({hi, lo}, 16'h0000);
      check({15'h0000, busy}, 16'h0000);
      check(16'(n_ms - bm), 16'h0002);
      $display("single shot done");
   endtask
   task automatic print_verdict;
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge core_clk);
      rst_b <= 1'b1;
      t_prescale;
      t_wraps;
      t_event_and_lp2;
      t_shot;
      print_verdict;
   end
endmodule
